// [inc/cfg_mode_pkg.sv]
// Constants and types for the configuration mode select and pull control
package cfg_mode_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] TAP_OFFSET    = 8'h08;

    // Control register: one 2-bit pull option per pin
    localparam logic [7:0] CTRL_RESET    = 8'h55;
    localparam int         OPT_BIT0_POS  = 0;
    localparam int         OPT_BIT1_POS  = 2;
    localparam int         OPT_BIT2_POS  = 4;
    localparam int         OPT_PUD_POS   = 6;
    localparam logic [1:0] PULL_NONE     = 2'h0;
    localparam logic [1:0] PULL_UP       = 2'h1;
    localparam logic [1:0] PULL_DOWN     = 2'h2;

    // Status register field positions
    localparam int ST_STRAP_POS = 0;
    localparam int ST_MODE_POS  = 3;
    localparam int ST_VALID_POS = 6;
    localparam int ST_DONE_POS  = 7;
    localparam int ST_START_POS = 8;
    localparam int ST_CAPT_POS  = 9;

    // Strap patterns as {bit2, bit1, bit0}
    localparam logic [2:0] STRAP_MASTER_SERIAL   = 3'h0;
    localparam logic [2:0] STRAP_SLAVE_SERIAL    = 3'h7;
    localparam logic [2:0] STRAP_MASTER_PARALLEL = 3'h3;
    localparam logic [2:0] STRAP_SLAVE_PARALLEL  = 3'h6;
    localparam logic [2:0] STRAP_BOUNDARY_SCAN   = 3'h5;

    // Test access port instruction register
    localparam int         IR_WIDTH   = 4;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam logic [3:0] IR_RESET   = 4'hf;

    typedef enum logic [2:0]
    {
        MODE_MASTER_SERIAL   = 3'h0,
        MODE_SLAVE_SERIAL    = 3'h1,
        MODE_SLAVE_PARALLEL  = 3'h2,
        MODE_MASTER_PARALLEL = 3'h3,
        MODE_BOUNDARY_SCAN   = 3'h6,
        MODE_RESERVED        = 3'h7
    } mode_type;

    typedef enum logic [3:0]
    {
        TAP_RESET    = 4'h0,
        TAP_IDLE     = 4'h1,
        TAP_SEL_DR   = 4'h3,
        TAP_CAP_DR   = 4'h2,
        TAP_SH_DR    = 4'h6,
        TAP_EX1_DR   = 4'h7,
        TAP_PA_DR    = 4'h5,
        TAP_EX2_DR   = 4'h4,
        TAP_UPD_DR   = 4'hc,
        TAP_SEL_IR   = 4'hd,
        TAP_CAP_IR   = 4'hf,
        TAP_SH_IR    = 4'he,
        TAP_EX1_IR   = 4'ha,
        TAP_PA_IR    = 4'hb,
        TAP_EX2_IR   = 4'h9,
        TAP_UPD_IR   = 4'h8
    } tap_state_type;

endpackage

// [hdl/config_mode_select_pull_control.sv]
// Configuration mode strap capture, pull-up control and test access port
//
// Notes on behaviour
// - Straps are captured at the rising edge of the initialisation flag.
// - 000 m-serial, 111 s-serial, 011 m-par, 110 s-par, 101 scan; rest reserved.
// - Strap pull-ups stay on before and during configuration, whatever disable.
// - Open straps pull high, decode to all ones, giving slave serial.
// - After successful configuration strap changes are ignored.
// - After configuration each strap gets its own stored pull option.
// - During configuration low disable input enables user pull-ups; high disables.
// - Configuration, test port and init pins always pulled up during configuration.
// - After configuration the disable input is ignored; user pull-ups go off.
// - After configuration the disable pin gets its own stored pull option.
// - Test port state advances only on the test clock rising edge; data out changes on the fall.
// - Test data input is sampled on the test clock rising edge only in the two shift states.
// - Test mode select is sampled on each rising edge to pick next state.
// - Test data output is actively driven, both levels, while shifting.
// - Reference-voltage pins behave as user pins, pull-ups included.
`timescale 1ns/1ps
`default_nettype none

module config_mode_select_pull_control
    import cfg_mode_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        mode_strap_bit2,
    input  wire logic        mode_strap_bit1,
    input  wire logic        mode_strap_bit0,
    input  wire logic        init_flag_n,
    input  wire logic        config_done,
    input  wire logic        config_pullup_disable,
    input  wire logic        tck,
    input  wire logic        tdi,
    input  wire logic        tms,
    output logic             tdo,
    output logic             tdo_oe,
    output mode_type         config_mode,
    output logic             mode_valid,
    output logic             config_start,
    output logic [2:0]       strap_pullup_en,
    output logic [2:0]       strap_pulldown_en,
    output logic             pud_pullup_en,
    output logic             pud_pulldown_en,
    output logic             user_io_pullup_en,
    output logic             dedicated_pullup_en
);

    logic [7:0]           ctrl;
    logic                 wr_pending;
    logic [7:0]           wr_addr;
    logic                 init_prev;
    logic                 done_seen;
    logic                 captured;
    logic [2:0]           strap_captured;
    logic                 tck_prev;
    tap_state_type        tap_state;
    tap_state_type        next_tap_state;
    logic [IR_WIDTH-1:0]  ir;
    logic [IR_WIDTH-1:0]  ir_shift;
    logic                 bypass;
    mode_type             next_mode;

    // Bus decode
    wire        access    = hsel & htrans[1] & hready;
    wire        rd_access = access & ~hwrite;
    wire [7:0]  addr_lo   = haddr[7:0];
    wire        hit_ctrl  = addr_lo == CTRL_OFFSET;
    wire        hit_stat  = addr_lo == STATUS_OFFSET;
    wire        hit_tap   = addr_lo == TAP_OFFSET;
    wire [31:0] status_word =
        (32'(strap_captured) << ST_STRAP_POS) |
        (32'(config_mode)    << ST_MODE_POS)  |
        (32'(mode_valid)     << ST_VALID_POS) |
        (32'(done_seen)      << ST_DONE_POS)  |
        (32'(config_start)   << ST_START_POS) |
        (32'(captured)       << ST_CAPT_POS);
    wire [31:0] tap_word = {24'h0, tap_state, ir};
    // Unmapped offsets read as zero and still answer OKAY
    wire [31:0] next_hrdata = hit_ctrl ? {24'h0, ctrl} :
                              hit_stat ? status_word :
                              hit_tap  ? tap_word : 32'h0;

    // Configuration phase
    wire init_rise   = init_flag_n & ~init_prev;
    wire capture     = init_rise & ~done_seen;
    wire configuring = ~done_seen;
    wire [2:0] straps = {mode_strap_bit2, mode_strap_bit1, mode_strap_bit0};
    wire next_valid  = captured & (next_mode != MODE_RESERVED);
    wire next_start  = next_valid & configuring;

    // Pull options stored by software, applied after configuration
    wire [1:0] opt_strap [3];
    assign opt_strap[0] = ctrl[OPT_BIT0_POS +: 2];
    assign opt_strap[1] = ctrl[OPT_BIT1_POS +: 2];
    assign opt_strap[2] = ctrl[OPT_BIT2_POS +: 2];
    wire [1:0] opt_pud  = ctrl[OPT_PUD_POS +: 2];

    wire [2:0] next_strap_up;
    wire [2:0] next_strap_down;
    genvar i;
    generate
        for (i = 0; i < 3; i++)
        begin : g_strap_pull
            // Pull-up during configuration keeps open straps at ones
            assign next_strap_up[i] = configuring |
                                      (opt_strap[i] == PULL_UP);
            assign next_strap_down[i] = ~configuring &
                                        (opt_strap[i] == PULL_DOWN);
        end
    endgenerate

    wire next_pud_up   = configuring | (opt_pud == PULL_UP);
    wire next_pud_down = ~configuring & (opt_pud == PULL_DOWN);
    // Reference-voltage pins are part of this user group
    wire next_user_up  = configuring & ~config_pullup_disable;

    // Test clock is sampled on hclk; edges are found by comparison
    wire tck_rise = tck & ~tck_prev;
    wire tck_fall = ~tck & tck_prev;

    always_comb
    begin
        unique case (straps_sel(strap_captured))
            STRAP_MASTER_SERIAL:   next_mode = MODE_MASTER_SERIAL;
            STRAP_SLAVE_SERIAL:    next_mode = MODE_SLAVE_SERIAL;
            STRAP_MASTER_PARALLEL: next_mode = MODE_MASTER_PARALLEL;
            STRAP_SLAVE_PARALLEL:  next_mode = MODE_SLAVE_PARALLEL;
            STRAP_BOUNDARY_SCAN:   next_mode = MODE_BOUNDARY_SCAN;
            default:               next_mode = MODE_RESERVED;
        endcase
    end

    function automatic logic [2:0] straps_sel(input logic [2:0] s);
        straps_sel = s;
    endfunction

    always_comb
    begin
        unique case (tap_state)
            TAP_RESET:  next_tap_state = tms ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:   next_tap_state = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: next_tap_state = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: next_tap_state = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  next_tap_state = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: next_tap_state = tms ? TAP_UPD_DR : TAP_PA_DR;
            TAP_PA_DR:  next_tap_state = tms ? TAP_EX2_DR : TAP_PA_DR;
            TAP_EX2_DR: next_tap_state = tms ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: next_tap_state = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: next_tap_state = tms ? TAP_RESET  : TAP_CAP_IR;
            TAP_CAP_IR: next_tap_state = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  next_tap_state = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: next_tap_state = tms ? TAP_UPD_IR : TAP_PA_IR;
            TAP_PA_IR:  next_tap_state = tms ? TAP_EX2_IR : TAP_PA_IR;
            TAP_EX2_IR: next_tap_state = tms ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: next_tap_state = tms ? TAP_SEL_DR : TAP_IDLE;
        endcase
    end

    // Bus slave: zero wait states, read data registered in address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            hrdata     <= 32'h0;
            wr_pending <= 1'b0;
            wr_addr    <= 8'h0;
            ctrl       <= CTRL_RESET;
        end
        else
        begin
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            wr_pending <= access & hwrite;
            wr_addr    <= addr_lo;
            if (rd_access)
                hrdata <= next_hrdata;
            if (wr_pending && wr_addr == CTRL_OFFSET)
                ctrl <= hwdata[7:0];
        end
    end

    // Strap capture and configuration state
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            init_prev      <= 1'b1;
            done_seen      <= 1'b0;
            captured       <= 1'b0;
            strap_captured <= STRAP_SLAVE_SERIAL;
        end
        else
        begin
            init_prev <= init_flag_n;
            // Done is sticky: later strap activity cannot reopen capture
            done_seen <= done_seen | config_done;
            if (capture)
            begin
                captured       <= 1'b1;
                strap_captured <= straps;
            end
        end
    end

    // Registered outputs of mode decode and pull control
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            config_mode         <= MODE_SLAVE_SERIAL;
            mode_valid          <= 1'b0;
            config_start        <= 1'b0;
            strap_pullup_en     <= 3'h7;
            strap_pulldown_en   <= 3'h0;
            pud_pullup_en       <= 1'b1;
            pud_pulldown_en     <= 1'b0;
            user_io_pullup_en   <= 1'b0;
            dedicated_pullup_en <= 1'b1;
        end
        else
        begin
            config_mode         <= next_mode;
            mode_valid          <= next_valid;
            config_start        <= next_start;
            strap_pullup_en     <= next_strap_up;
            strap_pulldown_en   <= next_strap_down;
            pud_pullup_en       <= next_pud_up;
            pud_pulldown_en     <= next_pud_down;
            user_io_pullup_en   <= next_user_up;
            dedicated_pullup_en <= configuring;
        end
    end

    // Test access port: state and registers move on test clock rise only
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tck_prev  <= 1'b0;
            tap_state <= TAP_RESET;
            ir        <= IR_RESET;
            ir_shift  <= IR_RESET;
            bypass    <= 1'b0;
        end
        else
        begin
            tck_prev <= tck;
            if (tck_rise)
            begin
                tap_state <= next_tap_state;
                unique case (tap_state)
                    TAP_RESET:  ir <= IR_RESET;
                    TAP_CAP_IR: ir_shift <= IR_CAPTURE;
                    TAP_SH_IR:  ir_shift <= {tdi, ir_shift[IR_WIDTH-1:1]};
                    TAP_UPD_IR: ir <= ir_shift;
                    TAP_CAP_DR: bypass <= 1'b0;
                    TAP_SH_DR:  bypass <= tdi;
                    default:    ;
                endcase
            end
        end
    end

    // Data out changes on the falling edge so the far side samples it on rise
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end
        else if (tck_fall)
        begin
            tdo_oe <= (tap_state == TAP_SH_IR) || (tap_state == TAP_SH_DR);
            tdo    <= (tap_state == TAP_SH_IR) ? ir_shift[0] : bypass;
        end
    end

    sequence s_init_rise;
        init_flag_n && !init_prev && !done_seen;
    endsequence

    sequence s_dr_shift_fall;
        tck_fall && tap_state == TAP_SH_DR;
    endsequence

    property p_capture;
        @(posedge hclk) disable iff (!hresetn)
        s_init_rise |=> captured && strap_captured == $past(straps);
    endproperty
    a_capture: assert property (p_capture)
        else $error("straps not captured at init flag rise");

    property p_decode_reserved;
        @(posedge hclk) disable iff (!hresetn)
        (strap_captured == 3'h1 || strap_captured == 3'h2 ||
         strap_captured == 3'h4) |=> !mode_valid && !config_start &&
                                     config_mode == MODE_RESERVED;
    endproperty
    a_decode_reserved: assert property (p_decode_reserved)
        else $error("reserved strap pattern treated as valid");

    property p_decode_scan;
        @(posedge hclk) disable iff (!hresetn)
        strap_captured == STRAP_BOUNDARY_SCAN |=>
            config_mode == MODE_BOUNDARY_SCAN;
    endproperty
    a_decode_scan: assert property (p_decode_scan)
        else $error("scan strap pattern decoded wrongly");

    property p_default_slave;
        @(posedge hclk) disable iff (!hresetn)
        captured && strap_captured == STRAP_SLAVE_SERIAL |=>
            config_mode == MODE_SLAVE_SERIAL && mode_valid;
    endproperty
    a_default_slave: assert property (p_default_slave)
        else $error("all-ones straps did not give slave serial");

    property p_strap_pullups;
        @(posedge hclk) disable iff (!hresetn)
        !done_seen |=> strap_pullup_en == 3'h7 && strap_pulldown_en == 3'h0;
    endproperty
    a_strap_pullups: assert property (p_strap_pullups)
        else $error("strap pull-ups off during configuration");

    property p_frozen;
        @(posedge hclk) disable iff (!hresetn)
        done_seen |=> $stable(strap_captured) && !config_start;
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("straps changed after configuration");

    property p_user_pullup;
        @(posedge hclk) disable iff (!hresetn)
        !done_seen |=> user_io_pullup_en == !$past(config_pullup_disable);
    endproperty
    a_user_pullup: assert property (p_user_pullup)
        else $error("user pull-up does not follow disable input");

    property p_after_config;
        @(posedge hclk) disable iff (!hresetn)
        done_seen |=> !user_io_pullup_en && !dedicated_pullup_en;
    endproperty
    a_after_config: assert property (p_after_config)
        else $error("configuration pull-ups left on in user mode");

    property p_option;
        @(posedge hclk) disable iff (!hresetn)
        done_seen && ctrl[OPT_BIT0_POS +: 2] == PULL_DOWN |=>
            strap_pulldown_en[0] && !strap_pullup_en[0];
    endproperty
    a_option: assert property (p_option)
        else $error("strap pull option not applied");

    property p_tap_hold;
        @(posedge hclk) disable iff (!hresetn)
        !tck_rise |=> $stable(tap_state);
    endproperty
    a_tap_hold: assert property (p_tap_hold)
        else $error("tap state moved without test clock rise");

    property p_tdo_drive;
        @(posedge hclk) disable iff (!hresetn)
        s_dr_shift_fall |=> tdo_oe && tdo == $past(bypass);
    endproperty
    a_tdo_drive: assert property (p_tdo_drive)
        else $error("test data output not driven from bypass");

endmodule // config_mode_select_pull_control

`default_nettype wire

// [bench/board_test_partner.sv]
// Board strap wiring and boundary-scan controller model
`timescale 1ns/1ps
`default_nettype none

module board_test_partner
(
    input  wire logic       hclk,
    input  wire logic [2:0] strap_pullup_en,
    input  wire logic [2:0] strap_pulldown_en,
    output logic            mode_strap_bit2,
    output logic            mode_strap_bit1,
    output logic            mode_strap_bit0,
    output logic            tck,
    output logic            tms,
    output logic            tdi
);
    logic [2:0] strap_drive;
    logic       strap_open;
    logic       float_level;
    logic [2:0] pin;

    initial
    begin
        strap_drive = 3'h0;
        strap_open  = 1'b1;
        float_level = 1'b0;
        tck         = 1'b0;
        tms         = 1'b1;
        tdi         = 1'b0;
    end

    // An open strap with no resistor must not look stable
    always @(posedge hclk)
        float_level <= ~float_level;

    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (!strap_open)
                pin[i] = strap_drive[i];
            else if (strap_pullup_en[i])
                pin[i] = 1'b1;
            else if (strap_pulldown_en[i])
                pin[i] = 1'b0;
            else
                pin[i] = float_level;
        end
    end

    assign mode_strap_bit2 = pin[2];
    assign mode_strap_bit1 = pin[1];
    assign mode_strap_bit0 = pin[0];

    task automatic set_straps(input logic [2:0] value, input logic open);
    begin
        @(posedge hclk);
        strap_drive <= value;
        strap_open  <= open;
    end
    endtask

    // Inputs move only while the test clock is low, ahead of its rise
    task automatic tap_step(input logic mode_sel, input logic data);
    begin
        @(posedge hclk);
        tms <= mode_sel;
        tdi <= data;
        repeat (3) @(posedge hclk);
        tck <= 1'b1;
        repeat (3) @(posedge hclk);
        tck <= 1'b0;
        repeat (3) @(posedge hclk);
    end
    endtask
endmodule // board_test_partner

`default_nettype wire

// [bench/tb_top.sv]
// Self-checking testbench for the mode select and pull control block
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import cfg_mode_pkg::*;
;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        strap2;
    logic        strap1;
    logic        strap0;
    logic        init_flag_n;
    logic        config_done;
    logic        config_pullup_disable;
    logic        tck;
    logic        tdi;
    logic        tms;
    logic        tdo;
    logic        tdo_oe;
    mode_type    config_mode;
    logic        mode_valid;
    logic        config_start;
    logic [2:0]  strap_pullup_en;
    logic [2:0]  strap_pulldown_en;
    logic        pud_pullup_en;
    logic        pud_pulldown_en;
    logic        user_io_pullup_en;
    logic        dedicated_pullup_en;
    int          err_count;
    int          total_checks;

    config_mode_select_pull_control config_mode_select_pull_control_i
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .mode_strap_bit2(strap2),
        .mode_strap_bit1(strap1), .mode_strap_bit0(strap0),
        .init_flag_n(init_flag_n), .config_done(config_done),
        .config_pullup_disable(config_pullup_disable), .tck(tck),
        .tdi(tdi), .tms(tms), .tdo(tdo), .tdo_oe(tdo_oe),
        .config_mode(config_mode), .mode_valid(mode_valid),
        .config_start(config_start), .strap_pullup_en(strap_pullup_en),
        .strap_pulldown_en(strap_pulldown_en),
        .pud_pullup_en(pud_pullup_en), .pud_pulldown_en(pud_pulldown_en),
        .user_io_pullup_en(user_io_pullup_en),
        .dedicated_pullup_en(dedicated_pullup_en)
    );

    board_test_partner partner_i
    (
        .hclk(hclk), .strap_pullup_en(strap_pullup_en),
        .strap_pulldown_en(strap_pulldown_en), .mode_strap_bit2(strap2),
        .mode_strap_bit1(strap1), .mode_strap_bit0(strap0),
        .tck(tck), .tms(tms), .tdi(tdi)
    );

    always #12.5 hclk = ~hclk;

    task automatic test_done;
    begin
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
    begin
        total_checks++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: %s got %h expected %h",
                     $time, what, got, exp);
            err_count++;
        end
    end
    endtask

    // Single word transfer; waits for ready in both phases
    task automatic ahb_xfer(input logic [31:0] a, input logic wr,
                            input logic [31:0] wd, output logic [31:0] rd);
    begin
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'b010;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    end
    endtask

    function automatic mode_type exp_mode(input logic [2:0] v);
        case (v)
            STRAP_MASTER_SERIAL:   return MODE_MASTER_SERIAL;
            STRAP_SLAVE_SERIAL:    return MODE_SLAVE_SERIAL;
            STRAP_MASTER_PARALLEL: return MODE_MASTER_PARALLEL;
            STRAP_SLAVE_PARALLEL:  return MODE_SLAVE_PARALLEL;
            STRAP_BOUNDARY_SCAN:   return MODE_BOUNDARY_SCAN;
            default:               return MODE_RESERVED;
        endcase
    endfunction

    task automatic capture(input logic [2:0] v, input logic open);
    begin
        partner_i.set_straps(v, open);
        repeat (2) @(posedge hclk);
        init_flag_n <= 1'b0;
        repeat (2) @(posedge hclk);
        init_flag_n <= 1'b1;
        repeat (3) @(posedge hclk);
        #1;
    end
    endtask

    task automatic run_regs;
        logic [31:0] rd;
    begin
        ahb_xfer({24'h0, CTRL_OFFSET}, 1'b0, 32'h0, rd);
        check(rd, 32'h0000_0055, "ctrl reset");
        ahb_xfer({24'h0, CTRL_OFFSET}, 1'b1, 32'hffff_ff89, rd);
        ahb_xfer({24'h0, CTRL_OFFSET}, 1'b0, 32'h0, rd);
        check(rd, 32'h0000_0089, "ctrl write");
        ahb_xfer({24'h0, STATUS_OFFSET}, 1'b1, 32'hffff_ffff, rd);
        ahb_xfer({24'h0, STATUS_OFFSET}, 1'b0, 32'h0, rd);
        check(rd[7], 1'b0, "status read only");
        ahb_xfer(32'h0000_0010, 1'b0, 32'h0, rd);
        check(rd, 32'h0, "unmapped read");
    end
    endtask

    task automatic run_modes;
        logic [31:0] rd;
        logic [2:0]  v;
        logic        ok;
    begin
        for (int i = 0; i < 8; i++)
        begin
            v = 3'(i);
            ok = (exp_mode(v) != MODE_RESERVED);
            capture(v, 1'b0);
            check(config_mode, exp_mode(v), "mode");
            check(mode_valid, ok, "valid");
            check(config_start, ok, "start");
            ahb_xfer({24'h0, STATUS_OFFSET}, 1'b0, 32'h0, rd);
            check(rd[2:0], v, "captured straps");
        end
        partner_i.set_straps(3'h0, 1'b0);
        repeat (4) @(posedge hclk);
        #1;
        check(config_mode, MODE_SLAVE_SERIAL, "no init rise");
        capture(3'h0, 1'b0);
        check(config_mode, MODE_MASTER_SERIAL, "master serial");
        capture(3'h0, 1'b1);
        check(config_mode, MODE_SLAVE_SERIAL, "open straps");
    end
    endtask

    task automatic run_pulls;
        logic lvl;
    begin
        for (int i = 0; i < 2; i++)
        begin
            lvl = i[0];
            @(posedge hclk);
            config_pullup_disable <= lvl;
            repeat (2) @(posedge hclk);
            #1;
            check(user_io_pullup_en, !lvl, "user pullup");
            check(strap_pullup_en, 3'h7, "strap pullup");
            check(dedicated_pullup_en, 1'b1, "dedicated");
            check(pud_pullup_en, 1'b1, "disable pin pullup");
        end
    end
    endtask

    task automatic run_tap;
        logic [31:0] rd;
    begin
        repeat (5) partner_i.tap_step(1'b1, 1'b0);
        ahb_xfer({24'h0, TAP_OFFSET}, 1'b0, 32'h0, rd);
        check(rd[7:0], {TAP_RESET, IR_RESET}, "tap reset");
        partner_i.tap_step(1'b0, 1'b1);
        partner_i.tap_step(1'b1, 1'b1);
        partner_i.tap_step(1'b0, 1'b1);
        partner_i.tap_step(1'b0, 1'b1);
        ahb_xfer({24'h0, TAP_OFFSET}, 1'b0, 32'h0, rd);
        check(rd[7:4], TAP_SH_DR, "tap state");
        check({tdo_oe, tdo}, 2'b10, "bypass capture");
        partner_i.tap_step(1'b0, 1'b1);
        check(tdo, 1'b1, "shift one");
        partner_i.tap_step(1'b0, 1'b0);
        check(tdo, 1'b0, "shift zero");
        partner_i.tap_step(1'b1, 1'b1);
        check(tdo_oe, 1'b0, "leave shift");
        partner_i.tap_step(1'b1, 1'b0);
        partner_i.tap_step(1'b0, 1'b0);
        repeat (2) partner_i.tap_step(1'b1, 1'b0);
        repeat (2) partner_i.tap_step(1'b0, 1'b0);
        check({tdo_oe, tdo}, 2'b11, "ir capture");
        for (int b = 0; b < 4; b++)
            partner_i.tap_step(b == 3, b[0]);
        partner_i.tap_step(1'b1, 1'b0);
        partner_i.tap_step(1'b0, 1'b0);
        ahb_xfer({24'h0, TAP_OFFSET}, 1'b0, 32'h0, rd);
        check(rd[7:0], {TAP_IDLE, 4'ha}, "ir update");
    end
    endtask

    task automatic run_done;
        logic [31:0] rd;
    begin
        capture(STRAP_SLAVE_PARALLEL, 1'b0);
        @(posedge hclk);
        config_pullup_disable <= 1'b0;
        config_done <= 1'b1;
        @(posedge hclk);
        config_done <= 1'b0;
        repeat (3) @(posedge hclk);
        #1;
        check(strap_pullup_en, 3'h1, "strap up option");
        check(strap_pulldown_en, 3'h2, "strap down option");
        check({pud_pullup_en, pud_pulldown_en}, 2'b01, "pud");
        check({user_io_pullup_en, dedicated_pullup_en}, 2'b00, "off");
        check(config_start, 1'b0, "start after done");
        capture(STRAP_MASTER_SERIAL, 1'b0);
        check(config_mode, MODE_SLAVE_PARALLEL, "frozen");
        ahb_xfer({24'h0, STATUS_OFFSET}, 1'b0, 32'h0, rd);
        check({rd[7], rd[2:0]}, 4'he, "done status");
    end
    endtask

    initial
    begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        init_flag_n = 1'b1;
        config_done = 1'b0;
        config_pullup_disable = 1'b1;
        err_count = 0;
        total_checks = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        #1;
        check({hreadyout, hresp}, 2'b10, "bus idle");
        check(strap_pullup_en, 3'h7, "strap pullup at reset");
        check(mode_valid, 1'b0, "no capture yet");
        run_regs();
        run_pulls();
        run_modes();
        run_tap();
        run_done();
        test_done();
    end

    initial
    begin
        repeat (5000) @(posedge hclk);
        err_count++;
        test_done();
    end
endmodule // tb_top

`default_nettype wire
